// ---- logic/lfcs_regs.vh ----
// Register map, field positions, reset values and divider counts of the LCD frame clock select block.
`ifndef LFCS_REGS_VH
`define LFCS_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define LFCS_ADDR_FRAME_CTRL   12'h000
`define LFCS_ADDR_WAVE_PUMP    12'h004
`define LFCS_ADDR_STATUS       12'h008

// ----------------------------------------------------------------------------
// Frame control fields
// ----------------------------------------------------------------------------
`define LFCS_FC_DISABLE_BIT    7
`define LFCS_FC_LADDER_BIT     6
`define LFCS_FC_ACTIVATE_BIT   5
`define LFCS_FC_DATA_SHOW_BIT  4
`define LFCS_FC_SYS_SEL_BIT    3
`define LFCS_FC_RESET          8'h80
// Bit 7 is not stored; it always reads back as one.
`define LFCS_FC_STORED_RESET   7'h00

// ----------------------------------------------------------------------------
// Waveform and pump control fields
// ----------------------------------------------------------------------------
`define LFCS_WP_WAVE_B_BIT     7
`define LFCS_WP_FIXED_ONE_BIT  6
`define LFCS_WP_PUMP_DIV8_BIT  5
`define LFCS_WP_RESET          8'h40

// ----------------------------------------------------------------------------
// Divider counts
// ----------------------------------------------------------------------------
`define LFCS_SYS_DIV_BASE      12'h010
`define LFCS_SUB_LAST_DIV1     2'h0
`define LFCS_SUB_LAST_DIV2     2'h1
`define LFCS_SUB_LAST_DIV4     2'h3
`define LFCS_FRAME_LAST_FULL   8'hFF
`define LFCS_FRAME_LAST_THIRD  8'hBF
`define LFCS_PUMP_HALF_DIV4    2'h1
`define LFCS_PUMP_HALF_DIV8    2'h3

`endif

// ---- logic/lfcs_sync_edge.v ----
// Two-flop synchroniser with a registered rising-edge pulse.
`timescale 1ns/100ps
module lfcs_sync_edge (
    input  wire pclk,
    input  wire presetn,
    input  wire level_in,
    output reg  rise_ff
);

    reg meta_ff;
    reg sync_ff;
    reg prev_ff;

    // The first stage feeds only the second stage.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else begin
            meta_ff <= level_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
            rise_ff <= sync_ff & ~prev_ff;
        end
    end

endmodule // lfcs_sync_edge

// ---- logic/lfcs_tick_div.v ----
// Programmable tick divider: one output pulse per last_count+1 enabled cycles.
`timescale 1ns/100ps
module lfcs_tick_div #(
    parameter W = 8
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         clear,
    input  wire         count_en,
    input  wire [W-1:0] last_count,
    output reg          tick_ff
);

    reg [W-1:0] cnt_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= {W{1'b0}};
            tick_ff <= 1'b0;
        end else if (clear) begin
            cnt_ff  <= {W{1'b0}};
            tick_ff <= 1'b0;
        end else if (count_en) begin
            if (cnt_ff >= last_count) begin
                cnt_ff  <= {W{1'b0}};
                tick_ff <= 1'b1;
            end else begin
                cnt_ff  <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
                tick_ff <= 1'b0;
            end
        end else begin
            tick_ff <= 1'b0;
        end
    end

endmodule // lfcs_tick_div

// ---- logic/lfcs_top.v ----
// LCD operating clock, frame rate, waveform and step-up clock selection with APB registers.
//
// Operation
// - Select bit 3 low: sub-clock divided by 1, 2 or 4; bit 2 ignored.
// - Select bit 3 high: system clock divided by 16 up to 2048, ascending.
// - In sub-clock power modes system-derived operating clock stops; no display.
// - One-third duty gives a frame rate four-thirds of nominal.
// - Sub-clock settings give 128, 64, 32 Hz at 32.768 kHz sub-clock.
// - Waveform bit 7: 0 selects A waveform, 1 B waveform; resets 0.
// - Waveform register bit 6 always reads 1; writes do not change it.
// - Pump divide bit: step-up clock is operating clock over 4 or 8.
// - Activate low stops controller and ladder; register contents kept.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "lfcs_regs.vh"
module lfcs_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sub_clk,
    input  wire        sub_mode_active,
    input  wire        duty_one_third,
    output reg         lcd_op_tick,
    output reg         lcd_frame_tick,
    output reg         pump_clk,
    output reg         drive_waveform_b,
    output reg         display_active,
    output reg         display_data_on,
    output reg         ladder_on
);

    // ------------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------------
    reg  [6:0]  frame_ctrl_ff;
    reg  [7:0]  wave_pump_ff;
    reg  [7:0]  frame_count_ff;
    reg  [6:0]  nxt_frame_ctrl;
    reg  [7:0]  nxt_wave_pump;
    reg  [7:0]  nxt_frame_count;
    reg  [31:0] nxt_prdata;
    reg         nxt_pslverr;
    reg  [31:0] rd_word;
    reg         addr_hit;

    wire        setup_phase;
    wire        access_done;
    wire        wr_frame_ctrl;
    wire        wr_wave_pump;

    wire [3:0]  frame_clock_select;
    wire        sys_source;
    wire        activate;
    wire        ladder_connect;
    wire        data_show;
    wire        pump_div8;

    wire        sub_rise;
    wire        sys_tick;
    wire        sub_tick;
    wire        frame_tick;
    wire        pump_half_tick;
    wire        op_tick;
    wire        op_running;
    wire        div_clear;

    wire [11:0] sys_last_wide;
    wire [10:0] sys_last;
    reg  [1:0]  sub_last;
    wire [7:0]  frame_last;
    wire [1:0]  pump_last;

    // ------------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------------
    assign frame_clock_select = frame_ctrl_ff[3:0];
    assign sys_source         = frame_ctrl_ff[`LFCS_FC_SYS_SEL_BIT];
    assign activate           = frame_ctrl_ff[`LFCS_FC_ACTIVATE_BIT];
    assign ladder_connect     = frame_ctrl_ff[`LFCS_FC_LADDER_BIT];
    assign data_show          = frame_ctrl_ff[`LFCS_FC_DATA_SHOW_BIT];
    assign pump_div8          = wave_pump_ff[`LFCS_WP_PUMP_DIV8_BIT];

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // The slave answers with one wait-free access phase: pready rises in the
    // cycle after setup, so every transfer takes exactly two cycles.
    assign setup_phase   = psel & ~penable;
    assign access_done   = psel & penable & pready;
    assign wr_frame_ctrl = access_done & pwrite & (paddr == `LFCS_ADDR_FRAME_CTRL);
    assign wr_wave_pump  = access_done & pwrite & (paddr == `LFCS_ADDR_WAVE_PUMP);

    always @* begin
        rd_word  = 32'h0000_0000;
        addr_hit = 1'b1;
        case (paddr)
            `LFCS_ADDR_FRAME_CTRL: begin
                // Bit 7 always reads as one.
                rd_word[7:0] = {1'b1, frame_ctrl_ff};
            end
            `LFCS_ADDR_WAVE_PUMP: begin
                rd_word[7:0] = wave_pump_ff | `LFCS_WP_RESET;
            end
            `LFCS_ADDR_STATUS: begin
                // Activity, source, running, power mode and frame count.
                rd_word[0]    = display_active;
                rd_word[1]    = ~sys_source;
                rd_word[2]    = op_running;
                rd_word[3]    = sub_mode_active;
                rd_word[15:8] = frame_count_ff;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always @* begin
        nxt_prdata  = prdata;
        nxt_pslverr = pslverr;
        if (setup_phase) begin
            nxt_prdata  = pwrite ? 32'h0000_0000 : rd_word;
            nxt_pslverr = ~addr_hit;
        end else if (access_done) begin
            nxt_prdata  = 32'h0000_0000;
            nxt_pslverr = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_phase;
            prdata  <= nxt_prdata;
            pslverr <= nxt_pslverr;
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    // Clearing activate stops the dividers and disconnects the ladder; the stored fields stay.
    always @* begin
        nxt_frame_ctrl = frame_ctrl_ff;
        nxt_wave_pump  = wave_pump_ff;
        if (wr_frame_ctrl) begin
            nxt_frame_ctrl = pwdata[6:0];
        end
        if (wr_wave_pump) begin
            // The reserved bit is forced high whatever is written.
            nxt_wave_pump = pwdata[7:0] | `LFCS_WP_RESET;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_ctrl_ff <= `LFCS_FC_STORED_RESET;
            wave_pump_ff  <= `LFCS_WP_RESET;
        end else begin
            frame_ctrl_ff <= nxt_frame_ctrl;
            wave_pump_ff  <= nxt_wave_pump;
        end
    end

    // ------------------------------------------------------------------------
    // Operating clock sources
    // ------------------------------------------------------------------------
    // The sub-clock is far slower than pclk and is sampled as a level.
    lfcs_sync_edge u_sub_edge (
        .pclk     (pclk),
        .presetn  (presetn),
        .level_in (sub_clk),
        .rise_ff  (sub_rise)
    );

    // Division 16 shifted left by the three low select bits.
    assign sys_last_wide = (`LFCS_SYS_DIV_BASE << frame_clock_select[2:0]) - 12'h001;
    assign sys_last      = sys_last_wide[10:0];

    always @* begin
        if (frame_clock_select[1]) begin
            sub_last = `LFCS_SUB_LAST_DIV4;
        end else if (frame_clock_select[0]) begin
            sub_last = `LFCS_SUB_LAST_DIV2;
        end else begin
            sub_last = `LFCS_SUB_LAST_DIV1;
        end
    end

    // Dividers restart on any frame control write so a new setting starts clean.
    assign div_clear = ~activate | wr_frame_ctrl;

    lfcs_tick_div #(.W(11)) u_sys_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (div_clear | ~sys_source),
        .count_en   (~sub_mode_active),
        .last_count (sys_last),
        .tick_ff    (sys_tick)
    );

    lfcs_tick_div #(.W(2)) u_sub_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (div_clear | sys_source),
        .count_en   (sub_rise),
        .last_count (sub_last),
        .tick_ff    (sub_tick)
    );

    // In sub-clock power modes the system clock is stopped, so only the
    // sub-clock path can keep the display alive.
    assign op_tick    = sys_source ? (sys_tick & ~sub_mode_active) : sub_tick;
    assign op_running = activate & ~(sys_source & sub_mode_active);

    // ------------------------------------------------------------------------
    // Frame and step-up clocks
    // ------------------------------------------------------------------------
    assign frame_last = duty_one_third ? `LFCS_FRAME_LAST_THIRD : `LFCS_FRAME_LAST_FULL;

    // One-third duty shortens the frame to 192 operating ticks.
    lfcs_tick_div #(.W(8)) u_frame_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (div_clear),
        .count_en   (op_tick),
        .last_count (frame_last),
        .tick_ff    (frame_tick)
    );

    // The step-up clock toggles every half period, so it leaves as a plain level.
    assign pump_last = pump_div8 ? `LFCS_PUMP_HALF_DIV8 : `LFCS_PUMP_HALF_DIV4;

    lfcs_tick_div #(.W(2)) u_pump_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (div_clear),
        .count_en   (op_tick),
        .last_count (pump_last),
        .tick_ff    (pump_half_tick)
    );

    // ------------------------------------------------------------------------
    // Frame counter
    // ------------------------------------------------------------------------
    // Software reads the count in the status word to see frames advance.
    always @* begin
        nxt_frame_count = frame_count_ff;
        if (frame_tick & activate) begin
            nxt_frame_count = frame_count_ff + 8'h01;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_count_ff <= 8'h00;
        end else begin
            frame_count_ff <= nxt_frame_count;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lcd_op_tick      <= 1'b0;
            lcd_frame_tick   <= 1'b0;
            pump_clk         <= 1'b0;
            drive_waveform_b <= 1'b0;
            display_active   <= 1'b0;
            display_data_on  <= 1'b0;
            ladder_on        <= 1'b0;
        end else begin
            lcd_op_tick      <= op_tick & activate;
            lcd_frame_tick   <= frame_tick & activate;
            drive_waveform_b <= wave_pump_ff[`LFCS_WP_WAVE_B_BIT];
            display_active   <= op_running;
            display_data_on  <= op_running & data_show;
            ladder_on        <= activate & ladder_connect;
            if (div_clear) begin
                pump_clk <= 1'b0;
            end else if (pump_half_tick) begin
                pump_clk <= ~pump_clk;
            end
        end
    end

endmodule // lfcs_top

// ---- test/lfcs_top_properties.sv ----
// Port checks of the LCD frame clock select block.
`timescale 1ns/100ps
module lfcs_top_properties (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        lcd_op_tick,
    input wire        drive_waveform_b,
    input wire        display_active,
    input wire        display_data_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire rd  = acc && !pwrite;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ans;
        pready ##1 !pready;
    endsequence
    property p_answer;
        s_setup |=> s_ans;
    endproperty
    property p_err;
        acc |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008);
    endproperty
    property p_rd_zero;
        rd && pslverr |-> prdata == 32'h0;
    endproperty
    property p_wave_rd;
        rd && paddr == 12'h004 |-> prdata[6] && prdata[31:8] == 24'h0;
    endproperty
    property p_fc_rd;
        rd && paddr == 12'h000 |-> prdata[7] && prdata[31:8] == 24'h0;
    endproperty
    property p_wave;
        acc && pwrite && paddr == 12'h004 |-> ##2 drive_waveform_b == $past(pwdata[7], 2);
    endproperty
    property p_data_on;
        display_data_on |-> display_active;
    endproperty
    property p_tick;
        lcd_op_tick |=> !lcd_op_tick;
    endproperty
    a_answer:  assert property (p_answer) else $error("pready not one cycle after setup");
    a_err:     assert property (p_err) else $error("pslverr wrong for address");
    a_rd_zero: assert property (p_rd_zero) else $error("error read data not zero");
    a_wave_rd: assert property (p_wave_rd) else $error("reserved bit not one");
    a_fc_rd:   assert property (p_fc_rd) else $error("frame control bit 7 not one");
    a_wave:    assert property (p_wave) else $error("waveform output wrong");
    a_data_on: assert property (p_data_on) else $error("data shown while inactive");
    a_tick:    assert property (p_tick) else $error("op tick longer than a cycle");
endmodule // lfcs_top_properties
bind lfcs_top lfcs_top_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lcd_op_tick(lcd_op_tick), .drive_waveform_b(drive_waveform_b), .display_active(display_active),
    .display_data_on(display_data_on));

// ---- test/test_lfcs_top.sv ----
// Self-checking testbench of the LCD frame clock select block.
`timescale 1ns/100ps
`include "lfcs_regs.vh"
module test_lfcs_top;
    logic        pclk, presetn, psel, penable, pwrite, sub_mode_active, duty_one_third;
    logic        sub_clk = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, lcd_op_tick, lcd_frame_tick, pump_clk, drive_waveform_b;
    logic        display_active, display_data_on, ladder_on, pump_q;
    logic [7:0]  v;
    wire  [2:0]  ev = {pump_clk & ~pump_q, lcd_frame_tick, lcd_op_tick};
    int          n_fail, compares, n, i;
    int          sc = 0;
    lfcs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sub_clk(sub_clk), .sub_mode_active(sub_mode_active), .duty_one_third(duty_one_third),
        .lcd_op_tick(lcd_op_tick), .lcd_frame_tick(lcd_frame_tick), .pump_clk(pump_clk),
        .drive_waveform_b(drive_waveform_b), .display_active(display_active),
        .display_data_on(display_data_on), .ladder_on(ladder_on));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // The sub-clock runs free with a period of 64 system cycles.
    always @(posedge pclk) begin
        pump_q <= pump_clk;
        sc <= (sc + 1) % 32;
        if (sc == 31) sub_clk <= ~sub_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin n_fail++; conclude(); end
        r = {pslverr, prdata};
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [32:0] exp);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        check(what, r[31:0], exp[31:0]);
        check(what, {31'h0, r[32]}, {31'h0, exp[32]});
    endtask
    // Cycles between two successive events of kind k.
    task automatic period(input int k, output int m);
        int t;
        t = 0;
        // A tick of the setting just replaced can still show one cycle after a write.
        repeat (2) @(negedge pclk);
        while (ev[k] !== 1'b1 && t < 40000) begin @(negedge pclk); t++; end
        m = 0;
        do begin @(negedge pclk); m++; end while (ev[k] !== 1'b1 && m < 40000);
        if (t >= 40000 || m >= 40000) begin n_fail++; conclude(); end
    endtask
    task automatic ticks(output int c);
        c = 0;
        repeat (2) @(negedge pclk);
        repeat (200) begin @(negedge pclk); c += (ev[0] !== 1'b0); end
    endtask
    function automatic int sub_mult(input logic [1:0] p);
        return p[1] ? 4 : (p[0] ? 2 : 1);
    endfunction
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        sub_mode_active = 1'b0; duty_one_third = 1'b0; n_fail = 0; compares = 0;
        void'($urandom(32'hE3888D59));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("frame_reset", `LFCS_ADDR_FRAME_CTRL, 33'h80);
        rdc("wave_reset", `LFCS_ADDR_WAVE_PUMP, 33'h40);
        rdc("unmapped", 12'h00C, 33'h1_0000_0000);
        rdc("status_reset", `LFCS_ADDR_STATUS, 33'h2);
        wr(`LFCS_ADDR_STATUS, 32'hFF);
        rdc("status_ro", `LFCS_ADDR_STATUS, 33'h2);
        v = 8'($urandom);
        wr(`LFCS_ADDR_WAVE_PUMP, {24'($urandom), 3'b100, v[4:0]});
        rdc("wave_rd", `LFCS_ADDR_WAVE_PUMP, {25'h0, 3'b110, v[4:0]});
        check("wave_b", drive_waveform_b, 1'b1);
        for (i = 0; i < 8; i++) begin
            wr(`LFCS_ADDR_FRAME_CTRL, 32'h78 | i);
            period(0, n);
            check("sys_op", n, 16 << i);
        end
        wr(`LFCS_ADDR_FRAME_CTRL, 32'h78);
        repeat (2) @(negedge pclk);
        check("active", {display_active, display_data_on, ladder_on}, 3'b111);
        period(1, n);
        check("frame", n, 4096);
        period(2, n);
        check("pump4", n, 64);
        wr(`LFCS_ADDR_WAVE_PUMP, 32'h20);
        repeat (2) @(negedge pclk);
        check("wave_a", drive_waveform_b, 1'b0);
        period(2, n);
        check("pump8", n, 128);
        @(posedge pclk);
        duty_one_third <= 1'b1;
        period(1, n);
        check("third", n, 3072);
        @(posedge pclk);
        duty_one_third <= 1'b0;
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(`LFCS_ADDR_FRAME_CTRL, {26'h0, 2'b10, 1'b0, v[0], i[1:0]});
            period(0, n);
            check("sub_op", n, 64 * sub_mult(i[1:0]));
        end
        wr(`LFCS_ADDR_FRAME_CTRL, 32'h20);
        period(1, n);
        check("sub_frame", n, 16384);
        @(posedge pclk);
        sub_mode_active <= 1'b1;
        period(0, n);
        check("sub_mode_op", n, 64);
        wr(`LFCS_ADDR_FRAME_CTRL, 32'h28);
        ticks(n);
        check("sys_stop", n, 0);
        check("sys_stop_act", display_active, 1'b0);
        @(posedge pclk);
        sub_mode_active <= 1'b0;
        wr(`LFCS_ADDR_FRAME_CTRL, 32'h48);
        ticks(n);
        check("idle_ticks", n, 0);
        check("idle_ladder", {display_active, ladder_on}, 2'b00);
        rdc("kept", `LFCS_ADDR_FRAME_CTRL, 33'hC8);
        conclude();
    end
endmodule // test_lfcs_top
